// ===== bench/pcl_link_monitor.sv
// checker: timing relations watched on the pins of the parallel config load link
`timescale 1ns/1ps
module pcl_link_monitor #(
   parameter int MIN_EDGES = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // link pins
   input wire logic restart_load_n,
   input wire logic load_ready_n,
   input wire logic load_complete,
   input wire logic load_clock,
   input wire logic startup_complete
);
   import pcl_pkg::*;
   // ready rises a few sync cycles later than the internal count ends
   localparam int RDY_MIN = STATUS_MIN_CYC - 10;
   localparam int HI_MAX  = T_STATUS_MAX_US * 1000 / CLK_NS;
   localparam int UM_MAX  = T_CD2UM_MAX_US * 1000 / CLK_NS;

   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   logic [19:0] lo_q, lo_d, hi_q, hi_d, cd_q, cd_d;
   logic [15:0] rise_q, rise_d;
   logic        clk_prev_q, rdy_prev_q;

   always_comb begin
      lo_d   = load_ready_n ? 20'h0_0000 : lo_q + 20'h0_0001;
      hi_d   = (load_ready_n || !restart_load_n) ? 20'h0_0000 : hi_q + 20'h0_0001;
      cd_d   = load_complete ? cd_q + 20'h0_0001 : 20'h0_0000;
      rise_d = (load_ready_n && !rdy_prev_q) ? 16'h0000 : rise_q + 16'(load_clock && !clk_prev_q);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         lo_q       <= '0;
         hi_q       <= '0;
         cd_q       <= '0;
         rise_q     <= '0;
         clk_prev_q <= 1'b0;
         rdy_prev_q <= 1'b0;
      end else begin
         lo_q       <= lo_d;
         hi_q       <= hi_d;
         cd_q       <= cd_d;
         rise_q     <= rise_d;
         clk_prev_q <= load_clock;
         rdy_prev_q <= load_ready_n;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_cd_low;
      $fell(restart_load_n) |-> ##[1:60] !load_complete;
   endproperty
   a_cd_low: assert property (p_cd_low) else $error("load_complete not low after restart");

   property p_rdy_low;
      $fell(restart_load_n) |-> ##[1:60] !load_ready_n;
   endproperty
   a_rdy_low: assert property (p_rdy_low) else $error("ready not low after restart");

   property p_rdy_min;
      $rose(load_ready_n) |-> lo_q >= RDY_MIN;
   endproperty
   a_rdy_min: assert property (p_rdy_min) else $error("ready low time too short");

   property p_rdy_max;
      hi_q <= HI_MAX;
   endproperty
   a_rdy_max: assert property (p_rdy_max) else $error("ready held low too long");

   property p_cd_hold;
      (!restart_load_n) [*8] |-> !load_complete;
   endproperty
   a_cd_hold: assert property (p_cd_hold) else $error("load_complete high during restart");

   property p_cd_edges;
      $rose(load_complete) |-> rise_q >= MIN_EDGES;
   endproperty
   a_cd_edges: assert property (p_cd_edges) else $error("load_complete before whole image");

   property p_cd_stay;
      (load_complete && restart_load_n) [*4] |=> load_complete;
   endproperty
   a_cd_stay: assert property (p_cd_stay) else $error("load_complete dropped without restart");

   property p_init_win;
      $rose(startup_complete) |-> (cd_q >= CD2UM_MIN_CYC) && (cd_q <= UM_MAX);
   endproperty
   a_init_win: assert property (p_init_win) else $error("init time out of window");

   property p_st_low;
      !startup_complete |-> load_complete;
   endproperty
   a_st_low: assert property (p_st_low) else $error("startup_complete low before complete");
endmodule // pcl_link_monitor

// ===== bench/tb.sv
// testbench: host and device joined over the link, full load and reload
`timescale 1ns/1ps
module tb;
   import pcl_pkg::*;
   logic               clk_sys, rst_n, start, startup_opt, word_in_valid;
   logic [RATIO_W-1:0] ratio;
   logic [WORDS_W-1:0] image_words;
   logic [DATA_W-1:0]  word_in, word_data;
   logic               word_in_ready, busy, done, hold_ready_n, word_valid, user_mode, user_io_oe_n;
   logic [DATA_W-1:0]  tx_q[$], rx_q[$];
   int                 error_cnt, checks, cyc;

   pcl_link_if pcl_link_if_inst ();
   pcl_host pcl_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(pcl_link_if_inst), .start(start),
      .ratio(ratio), .image_words(image_words), .word_in(word_in), .word_in_valid(word_in_valid),
      .word_in_ready(word_in_ready), .busy(busy), .done(done), .hold_ready_n(hold_ready_n));
   pcl_device pcl_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(pcl_link_if_inst), .ratio(ratio),
      .image_words(image_words), .startup_opt(startup_opt), .word_data(word_data), .word_valid(word_valid),
      .user_mode(user_mode), .user_io_oe_n(user_io_oe_n));
   pcl_link_monitor #(.MIN_EDGES(8)) pcl_link_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .restart_load_n(pcl_link_if_inst.restart_load_n), .load_ready_n(pcl_link_if_inst.load_ready_n),
      .load_complete(pcl_link_if_inst.load_complete), .load_clock(pcl_link_if_inst.load_clock),
      .startup_complete(pcl_link_if_inst.startup_complete));

   // ----------------------------------------
   // clock, timeout, word feed and capture
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // three long waits plus init stay near 99k cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 110000) begin
         error_cnt++;
         end_sim();
      end
   end

   always @(posedge clk_sys) begin
      if (word_valid === 1'b1) rx_q.push_back(word_data);
      if (word_in_valid === 1'b1 && word_in_ready === 1'b1) void'(tx_q.pop_front());
      #1;
      word_in_valid = tx_q.size() > 0;
      word_in = (tx_q.size() > 0) ? tx_q[0] : '0;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task chk(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   task chk_bit(input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   task chk_rng(input int v, input int lo, input int hi);
      checks++;
      if (v < lo || v > hi) begin
         error_cnt++;
         $display("wrong value at %0t: expected %h..%h got %h", $time, lo, hi, v);
      end
   endtask

   task end_sim;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_por;
      int w;
      w = 0;
      while (hold_ready_n !== 1'b1 && w < 40000) begin
         tick(1);
         w++;
      end
      chk_rng(w, POR_CYC, POR_CYC + 20);
      chk_bit(1'b0, pcl_link_if_inst.load_complete);
      chk_bit(1'b1, user_io_oe_n);
      $display("test power-on done");
   endtask

   task t_load(input logic [RATIO_W-1:0] r, input logic [WORDS_W-1:0] n, input logic [DATA_W-1:0] base);
      int w;
      int k;
      ratio = r;
      image_words = n;
      rx_q.delete();
      for (k = 0; k < int'(n); k++) tx_q.push_back(base + DATA_W'(k) * 32'h0101_0101);
      start = 1'b1;
      tick(1);
      start = 1'b0;
      w = 0;
      while (pcl_link_if_inst.restart_load_n !== 1'b0 && w < 50) begin
         tick(1);
         w++;
      end
      w = 0;
      while ((pcl_link_if_inst.load_ready_n !== 1'b0 || pcl_link_if_inst.load_complete !== 1'b0) && w < 80) begin
         tick(1);
         w++;
      end
      chk_rng(w, 0, 60);
      chk_bit(1'b0, user_mode);
      chk_bit(1'b1, busy);
      // done lags the pin by its sync flops
      tick(4);
      w = 0;
      while (done !== 1'b1 && w < 40000) begin
         chk_bit(1'b1, user_io_oe_n);
         tick(1);
         w++;
      end
      chk(DATA_W'(n), DATA_W'(rx_q.size()));
      for (k = 0; k < int'(n); k++) chk(base + DATA_W'(k) * 32'h0101_0101, rx_q[k]);
      chk_bit(!startup_opt, pcl_link_if_inst.startup_complete);
      $display("test load ratio %0d done", r);
   endtask

   task t_init;
      int w;
      w = 0;
      while (user_mode !== 1'b1 && w < 50000) begin
         tick(1);
         w++;
      end
      chk_rng(w, CD2UM_MIN_CYC - 10, T_CD2UM_MAX_US * 1000 / CLK_NS);
      chk_bit(1'b0, user_io_oe_n);
      chk_bit(1'b0, busy);
      chk_bit(1'b1, pcl_link_if_inst.startup_complete);
      chk_bit(1'b1, pcl_link_if_inst.load_ready_n);
      tick(100);
      chk_bit(1'b1, pcl_link_if_inst.load_complete);
      $display("test init done");
   endtask

   initial begin
      rst_n = 1'b0;
      start = 1'b0;
      startup_opt = 1'b1;
      ratio = 3'h2;
      image_words = 16'h0004;
      word_in = '0;
      word_in_valid = 1'b0;
      error_cnt = 0;
      checks = 0;
      cyc = 0;
      tick(2);
      rst_n = 1'b1;
      t_por();
      t_load(3'h2, 16'h0004, 32'hA5A5_0000);
      t_init();
      // reload from user mode, no startup option, longest ratio
      startup_opt = 1'b0;
      t_load(RATIO_MAX, 16'h0003, 32'h1234_5678);
      end_sim();
   end
endmodule // tb

// ===== verilog/pcl_device.sv
// module: device end, receives words and runs reset, load and startup sequencing
// Contract
// R1: user mode: all high; restart low reconfigures
// R2: load_complete low within 600 ns
// R3: load_ready_n low within 600 ns
// R4: host holds restart low at least 2 us
// R5: ready low 268 us min, 1506 max
// R6: ready released within 1506 us of restart
// R7: host waits 2 us after ready rises
// R8: ready low for power-on delay
// R9: load_complete low until configuration done
// R10: each word held r load_clock cycles
// R11: host holds data N-1 periods after sample
// R12: host load_clock at most 100/125 MHz
// R13: host pauses low, data valid before resuming
// R14: load_complete high only after full image
// R15: two falling edges after complete start init
// R16: load_clock ignored once configuration completes
// R17: user mode 175 to 437 us after complete
// R18: startup_complete low once option loaded
// R19: ratio above one with decompression or security
// R20: user pins high impedance until user mode
`timescale 1ns/1ps
module pcl_device (
   // system
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   // link pins
   pcl_link_if.device_mp                link,
   // configuration setup from the user side
   input  wire logic [pcl_pkg::RATIO_W-1:0] ratio,
   input  wire logic [pcl_pkg::WORDS_W-1:0] image_words,
   input  wire logic                    startup_opt,
   // received words and status
   output      logic [pcl_pkg::DATA_W-1:0] word_data,
   output      logic                    word_valid,
   output      logic                    user_mode,
   output      logic                    user_io_oe_n
);
   import pcl_pkg::*;
   typedef enum logic [2:0] {PCL_POR, PCL_RESET, PCL_WAIT, PCL_LOAD, PCL_CLOSE, PCL_INIT, PCL_USER} pcl_dev_st_t;

   logic        rst_pin_s, rdy_pin_s;
   pcl_edge_t   rst_edge, clk_edge;
   logic [DATA_W-1:0] data_s1_q, data_s2_q;

   pcl_sync u_sync_rst (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(link.restart_load_n),
                        .sync_out(rst_pin_s), .edge_out(rst_edge));
   pcl_sync u_sync_clk (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(link.load_clock),
                        .sync_out(), .edge_out(clk_edge));
   // the ready pin is shared with the far side, so it is resynchronised too
   pcl_sync u_sync_rdy (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(link.load_ready_n),
                        .sync_out(rdy_pin_s), .edge_out());

   // ------------------------------------------------------------
   // data bus capture; stable r link periods, so two flops suffice
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         data_s1_q <= 32'h0000_0000;
         data_s2_q <= 32'h0000_0000;
      end else begin
         data_s1_q <= link.load_data;
         data_s2_q <= data_s1_q;
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   pcl_dev_st_t           st_q, st_d;
   logic [CNT_W-1:0]      cnt_q, cnt_d;
   logic [RATIO_W-1:0]    phase_q, phase_d;
   logic [WORDS_W-1:0]    words_q, words_d;
   logic [1:0]            falls_q, falls_d;
   logic                  ready_low_q, ready_low_d;
   logic                  done_q, done_d;
   logic                  init_n_q, init_n_d;
   logic                  opt_q, opt_d;
   logic [DATA_W-1:0]     word_q, word_d;
   logic                  wvalid_q, wvalid_d;
   logic                  ratio_ok;

   // r of one degenerates to one sample a rising edge
   assign ratio_ok = (ratio >= RATIO_ONE) && (ratio <= RATIO_MAX); // [R19]

   always_comb begin
      st_d        = st_q;
      cnt_d       = cnt_q;
      phase_d     = phase_q;
      words_d     = words_q;
      falls_d     = falls_q;
      ready_low_d = ready_low_q;
      done_d      = done_q;
      init_n_d    = init_n_q;
      opt_d       = opt_q;
      word_d      = word_q;
      wvalid_d    = 1'b0;
      unique case (st_q)
         PCL_POR: begin
            ready_low_d = 1'b1; // [R8]
            done_d      = 1'b0; // [R9]
            cnt_d       = cnt_q + 1'b1;
            if (cnt_q >= CNT_W'(POR_CYC - 1)) begin
               st_d        = PCL_WAIT;
               cnt_d       = '0;
            end
         end
         PCL_RESET: begin
            // ready held low at least its minimum; ends once that count is reached and restart is back high
            ready_low_d = 1'b1; // [R3] [R5]
            done_d      = 1'b0; // [R2]
            if (cnt_q < CNT_W'(STATUS_MIN_CYC)) begin
               cnt_d = cnt_q + 1'b1; // [R5]
            end
            if (rst_pin_s && cnt_q >= CNT_W'(STATUS_MIN_CYC)) begin
               st_d = PCL_WAIT; // [R6]
               cnt_d = '0;
            end
         end
         PCL_WAIT: begin
            ready_low_d = 1'b0;
            phase_d     = '0;
            words_d     = '0;
            falls_d     = '0;
            // external low on ready stretches the wait
            if (rdy_pin_s && ratio_ok) begin
               st_d = PCL_LOAD;
            end
         end
         PCL_LOAD: begin
            if (clk_edge == PCL_EDGE_RISE) begin
               if (phase_q == '0) begin
                  word_d   = data_s2_q; // [R10] [R13]
                  wvalid_d = 1'b1;
                  words_d  = words_q + 1'b1;
               end
               if (phase_q == ratio - 1'b1) begin
                  phase_d = '0; // [R10]
                  // words_q already counts this word unless it is also taken on this edge
                  if ((phase_q == '0) ? (words_q + 1'b1 >= image_words) : (words_q >= image_words)) begin
                     st_d   = PCL_CLOSE;
                     done_d = 1'b1; // [R14]
                     opt_d  = startup_opt; // [R18]
                  end
               end else begin
                  phase_d = phase_q + 1'b1;
               end
            end
         end
         PCL_CLOSE: begin
            if (clk_edge == PCL_EDGE_FALL) begin
               falls_d = falls_q + 1'b1;
               if (falls_q == 2'(CLOSE_EDGES - 1)) begin
                  st_d  = PCL_INIT; // [R15]
                  cnt_d = '0;
               end
            end
            if (opt_q) begin
               init_n_d = 1'b0; // [R18]
            end
         end
         PCL_INIT: begin
            // load_clock no longer looked at
            cnt_d = cnt_q + 1'b1; // [R16]
            if (cnt_q >= CNT_W'(CD2UM_MIN_CYC - 1)) begin
               st_d     = PCL_USER; // [R17]
               init_n_d = 1'b1; // [R18]
            end
         end
         PCL_USER: begin
            done_d = 1'b1; // [R1]
         end
         default: st_d = PCL_POR;
      endcase
      // restart outranks every state but power-on
      if (rst_edge == PCL_EDGE_FALL && st_q != PCL_POR) begin
         st_d        = PCL_RESET; // [R1]
         cnt_d       = '0;
         ready_low_d = 1'b1; // [R3]
         done_d      = 1'b0; // [R2]
         init_n_d    = 1'b1;
         opt_d       = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q        <= PCL_POR;
         cnt_q       <= '0;
         phase_q     <= '0;
         words_q     <= '0;
         falls_q     <= '0;
         ready_low_q <= 1'b1;
         done_q      <= 1'b0;
         init_n_q    <= 1'b1;
         opt_q       <= 1'b0;
         word_q      <= 32'h0000_0000;
         wvalid_q    <= 1'b0;
      end else begin
         st_q        <= st_d;
         cnt_q       <= cnt_d;
         phase_q     <= phase_d;
         words_q     <= words_d;
         falls_q     <= falls_d;
         ready_low_q <= ready_low_d;
         done_q      <= done_d;
         init_n_q    <= init_n_d;
         opt_q       <= opt_d;
         word_q      <= word_d;
         wvalid_q    <= wvalid_d;
      end
   end

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   assign link.load_ready_n_o    = 1'b0;
   assign link.load_ready_n_oe_n = !ready_low_q; // open drain, drives only low
   assign link.load_complete     = done_q; // [R9]
   assign link.startup_complete  = init_n_q;
   assign word_data              = word_q;
   assign word_valid             = wvalid_q;
   assign user_mode              = (st_q == PCL_USER);
   assign user_io_oe_n           = (st_q != PCL_USER); // [R20]
endmodule // pcl_device

// ===== verilog/pcl_host.sv
// module: host end, restarts the device and streams the image over the link
`timescale 1ns/1ps
module pcl_host (
   // system
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   // link pins
   pcl_link_if.host_mp                  link,
   // user side
   input  wire logic                    start,
   input  wire logic [pcl_pkg::RATIO_W-1:0] ratio,
   input  wire logic [pcl_pkg::WORDS_W-1:0] image_words,
   input  wire logic [pcl_pkg::DATA_W-1:0]  word_in,
   input  wire logic                    word_in_valid,
   output      logic                    word_in_ready,
   output      logic                    busy,
   output      logic                    done,
   output      logic                    hold_ready_n
);
   import pcl_pkg::*;
   typedef enum logic [2:0] {PCL_H_IDLE, PCL_H_PULSE, PCL_H_READY, PCL_H_GAP, PCL_H_SEND, PCL_H_DONE, PCL_H_TAIL}
      pcl_host_st_t;

   logic       rdy_s, cmp_s;
   pcl_edge_t  rdy_edge;
   pcl_sync u_sync_rdy (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(link.load_ready_n),
                        .sync_out(rdy_s), .edge_out(rdy_edge));
   pcl_sync u_sync_cmp (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(link.load_complete),
                        .sync_out(cmp_s), .edge_out());

   pcl_host_st_t          st_q, st_d;
   logic [CNT_W-1:0]      cnt_q, cnt_d;
   logic [3:0]            div_q, div_d;
   logic                  lclk_q, lclk_d;
   logic [RATIO_W-1:0]    phase_q, phase_d;
   logic [WORDS_W-1:0]    sent_q, sent_d;
   logic [1:0]            falls_q, falls_d;
   logic [DATA_W-1:0]     data_q, data_d;
   logic                  have_q, have_d;
   logic                  rst_n_q, rst_n_d;

   always_comb begin
      st_d     = st_q;
      cnt_d    = cnt_q;
      div_d    = div_q;
      lclk_d   = lclk_q;
      phase_d  = phase_q;
      sent_d   = sent_q;
      falls_d  = falls_q;
      data_d   = data_q;
      have_d   = have_q;
      rst_n_d  = rst_n_q;
      word_in_ready = 1'b0;
      unique case (st_q)
         PCL_H_IDLE: begin
            if (start) begin
               st_d    = PCL_H_PULSE;
               rst_n_d = 1'b0;
               cnt_d   = '0;
            end
         end
         PCL_H_PULSE: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q >= CNT_W'(CFG_MIN_CYC - 1)) begin
               rst_n_d = 1'b1; // [R4]
               st_d    = PCL_H_READY;
            end
         end
         PCL_H_READY: begin
            if (rdy_edge == PCL_EDGE_RISE) begin
               st_d  = PCL_H_GAP;
               cnt_d = '0;
            end
         end
         PCL_H_GAP: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q >= CNT_W'(ST2CK_MIN_CYC - 1)) begin
               st_d    = PCL_H_SEND; // [R7]
               div_d   = '0;
               phase_d = '0;
               sent_d  = '0;
               have_d  = 1'b0;
            end
         end
         PCL_H_SEND: begin
            // clock parks low until the next word is on the bus
            if (!have_q && !lclk_q) begin
               word_in_ready = 1'b1; // [R13]
               if (word_in_valid) begin
                  data_d = word_in;
                  have_d = 1'b1;
               end
            end else if (have_q) begin
               div_d = div_q + 1'b1; // [R12]
               if (div_q == 4'(LCLK_HALF_CYC - 1)) begin
                  div_d  = '0;
                  lclk_d = !lclk_q;
                  if (lclk_q) begin
                     // falling edge closes one cycle of the word
                     if (phase_q == ratio - 1'b1) begin
                        phase_d = '0; // [R10] [R11]
                        have_d  = 1'b0;
                        sent_d  = sent_q + 1'b1;
                        if (sent_q + 1'b1 >= image_words) begin
                           st_d = PCL_H_DONE; // [R14]
                        end
                     end else begin
                        phase_d = phase_q + 1'b1;
                     end
                  end
               end
            end
         end
         PCL_H_DONE: begin
            if (cmp_s) begin
               st_d    = PCL_H_TAIL;
               falls_d = '0;
               div_d   = '0;
            end
         end
         PCL_H_TAIL: begin
            div_d = div_q + 1'b1;
            if (div_q == 4'(LCLK_HALF_CYC - 1)) begin
               div_d  = '0;
               lclk_d = !lclk_q;
               if (lclk_q) begin
                  falls_d = falls_q + 1'b1;
                  if (falls_q == 2'(CLOSE_EDGES - 1)) begin
                     st_d = PCL_H_IDLE; // [R15]
                  end
               end
            end
         end
         default: st_d = PCL_H_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q    <= PCL_H_IDLE;
         cnt_q   <= '0;
         div_q   <= '0;
         lclk_q  <= 1'b0;
         phase_q <= '0;
         sent_q  <= '0;
         falls_q <= '0;
         data_q  <= 32'h0000_0000;
         have_q  <= 1'b0;
         rst_n_q <= 1'b1;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         div_q   <= div_d;
         lclk_q  <= lclk_d;
         phase_q <= phase_d;
         sent_q  <= sent_d;
         falls_q <= falls_d;
         data_q  <= data_d;
         have_q  <= have_d;
         rst_n_q <= rst_n_d;
      end
   end

   assign link.restart_load_n    = rst_n_q; // [R1]
   assign link.load_clock        = lclk_q; // [R16]
   assign link.load_data         = data_q;
   assign link.load_ready_n_host = 1'b1;
   assign busy                   = (st_q != PCL_H_IDLE);
   assign done                   = cmp_s;
   assign hold_ready_n           = rdy_s;
endmodule // pcl_host

// ===== verilog/pcl_link_if.sv
// interface: pins joining host and device of the parallel config load port
`timescale 1ns/1ps
interface pcl_link_if;
   import pcl_pkg::*;
   logic                restart_load_n;
   logic                load_ready_n_o;
   logic                load_ready_n_oe_n;
   logic                load_ready_n_host;
   wire                 load_ready_n;
   logic                load_complete;
   logic                load_clock;
   logic [DATA_W-1:0]   load_data;
   logic                startup_complete;
   // open drain: low wins from either party
   assign load_ready_n = (!load_ready_n_oe_n && !load_ready_n_o) ? 1'b0 : load_ready_n_host;
   modport device_mp (input restart_load_n, input load_clock, input load_data, input load_ready_n,
                      output load_ready_n_o, output load_ready_n_oe_n, output load_complete,
                      output startup_complete);
   modport host_mp   (output restart_load_n, output load_clock, output load_data, output load_ready_n_host,
                      input load_ready_n, input load_complete, input startup_complete);
endinterface

// ===== verilog/pcl_pkg.sv
// package: constants and types shared by both ends of the parallel config load port
package pcl_pkg;
   localparam int CLK_NS            = 10;
   // device side timing, figures as printed
   localparam int T_CF2CD_NS        = 600;
   localparam int T_CF2ST0_NS       = 600;
   localparam int T_STATUS_MIN_US   = 268;
   localparam int T_STATUS_MAX_US   = 1506;
   localparam int T_CFG_MIN_US      = 2;
   localparam int T_ST2CK_MIN_US    = 2;
   localparam int T_CD2UM_MIN_US    = 175;
   localparam int T_CD2UM_MAX_US    = 437;
   localparam int T_POR_US          = 268;
   // cycle counts: least times round up, longest round down
   localparam int CF2CD_CYC         = T_CF2CD_NS / CLK_NS;
   localparam int STATUS_MIN_CYC    = (T_STATUS_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int CFG_MIN_CYC       = (T_CFG_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int ST2CK_MIN_CYC     = (T_ST2CK_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int CD2UM_MIN_CYC     = (T_CD2UM_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int POR_CYC           = (T_POR_US * 1000 + CLK_NS - 1) / CLK_NS;
   // bus shape and ratio
   localparam int DATA_W            = 32;
   localparam int RATIO_W           = 3;
   localparam int WORDS_W           = 16;
   localparam int CNT_W             = 20;
   localparam logic [RATIO_W-1:0] RATIO_ONE = 3'h1;
   localparam logic [RATIO_W-1:0] RATIO_MAX = 3'h4;
   localparam int LCLK_HALF_CYC     = 8;
   localparam int CLOSE_EDGES       = 2;
   typedef enum logic [1:0] {PCL_EDGE_NONE, PCL_EDGE_RISE, PCL_EDGE_FALL} pcl_edge_t;
endpackage

// ===== verilog/pcl_sync.sv
// module: two-flop synchroniser with edge detect on the resynchronised level
`timescale 1ns/1ps
module pcl_sync (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // level in and out
   input  wire logic             async_in,
   output      logic             sync_out,
   output      pcl_pkg::pcl_edge_t edge_out
);
   import pcl_pkg::*;
   logic [2:0] sh_q;
   logic [2:0] sh_d;
   always_comb begin
      sh_d = {sh_q[1:0], async_in};
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sh_q <= 3'h0; // idle-low pins show no false edge after reset
      end else begin
         sh_q <= sh_d;
      end
   end
   assign sync_out = sh_q[1];
   // edge only from second and third flop, first flop stays private
   assign edge_out = (sh_q[1] && !sh_q[2]) ? PCL_EDGE_RISE :
                     (!sh_q[1] && sh_q[2]) ? PCL_EDGE_FALL : PCL_EDGE_NONE;
endmodule // pcl_sync
